// *** logic/ccdm_acc_if.sv ***
`timescale 1ns/1ps
interface ccdm_acc_if;
	import ccdm_pkg::*;

	logic       start;
	ccdm_kind_t kind;
	logic       busy;
	logic       done;
	logic       ce;
	logic       we;
	logic       rdBit;

	modport ctl (output start, kind, input busy, done, ce, we, rdBit);
	modport seq (input start, kind, output busy, done, ce, we, rdBit);
endinterface

// *** logic/ccdm_cfg.svh ***
`ifndef CCDM_CFG_SVH
`define CCDM_CFG_SVH

`define CCDM_CLK_NS        10
`define CCDM_UP(t)         (((t) + `CCDM_CLK_NS - 1) / `CCDM_CLK_NS)
`define CCDM_DN(t)         ((t) / `CCDM_CLK_NS)

`define CCDM_LOOPS         64
`define CCDM_LOOP_BITS     256
`define CCDM_ADDR_W        6
`define CCDM_MAX_ACC       16

`define CCDM_T_PT_NS       200
`define CCDM_T_OV_NS       30
`define CCDM_T_HD_NS       40
`define CCDM_T_FC_NS       280
`define CCDM_T_CP_NS       40
`define CCDM_T_HALF_MIN_NS 750
`define CCDM_T_HALF_MAX_NS 10000
`define CCDM_T_CO_NS       250
`define CCDM_T_CE_OFF_NS   140
`define CCDM_T_RD_CYC_NS   460
`define CCDM_T_WR_CYC_NS   460
`define CCDM_T_RTW_CYC_NS  620
`define CCDM_T_CER_NS      280
`define CCDM_T_CEW_NS      280
`define CCDM_T_CRW_NS      440
`define CCDM_T_CW_NS       100
`define CCDM_T_WP_NS       100
`define CCDM_T_WD_NS       300

`define CCDM_PT_CYC        `CCDM_UP(`CCDM_T_PT_NS)
`define CCDM_OV_CYC        `CCDM_UP(`CCDM_T_OV_NS)
`define CCDM_HD_CYC        `CCDM_UP(`CCDM_T_HD_NS)
`define CCDM_FC_CYC        `CCDM_UP(`CCDM_T_FC_NS)
`define CCDM_CP_CYC        `CCDM_UP(`CCDM_T_CP_NS)
`define CCDM_HALF_MIN_CYC  `CCDM_UP(`CCDM_T_HALF_MIN_NS)
`define CCDM_CO_CYC        `CCDM_UP(`CCDM_T_CO_NS)
`define CCDM_OFF_CYC       `CCDM_UP(`CCDM_T_CE_OFF_NS)
`define CCDM_RD_CYC        `CCDM_UP(`CCDM_T_RD_CYC_NS)
`define CCDM_WR_CYC        `CCDM_UP(`CCDM_T_WR_CYC_NS)
`define CCDM_RTW_CYC       `CCDM_UP(`CCDM_T_RTW_CYC_NS)
`define CCDM_CER_CYC       `CCDM_UP(`CCDM_T_CER_NS)
`define CCDM_CEW_CYC       `CCDM_UP(`CCDM_T_CEW_NS)
`define CCDM_CRW_CYC       `CCDM_UP(`CCDM_T_CRW_NS)
`define CCDM_CW_CYC        `CCDM_UP(`CCDM_T_CW_NS)
`define CCDM_WP_CYC        `CCDM_UP(`CCDM_T_WP_NS)
`define CCDM_WD_CYC        `CCDM_UP(`CCDM_T_WD_NS)

`endif

// *** logic/ccdm_ctrl.sv ***
`timescale 1ns/1ps
`include "ccdm_cfg.svh"

// Summary of operation
// - access only in window, at most 16
// - strobe frames cycle; write strobe marks store
// - write strobe stays low in pure reads
// - inverted data valid 250 ns after strobe
// - strobe rises 280 ns after phase falls
// - strobe low 40 ns before next shift
// - every half period at most 10000 ns
// - phase one/three 200 ns after two/four
// - handover overlap of phases at least 30 ns
// - select settled at strobe rise, held through
// - write pulse 100 ns late, 100 ns wide
// - write strobe 280 ns, cycle 460 ns
// - read_then_write strobe 440, cycle 620 ns
// - read_then_write pulse 300 ns late, 100 wide
// - strobe low 140 ns, read cycle 460
module ccdm_ctrl #(
	parameter int ADDR_W      = `CCDM_ADDR_W,
	parameter int MAX_ACC     = `CCDM_MAX_ACC,
	parameter int HALF_MAX_NS = `CCDM_T_HALF_MAX_NS
) (
	input  wire logic                 sys_clk,
	input  wire logic                 rst_n,
	input  wire logic                 reqValid,
	output logic                      reqReady,
	input  wire ccdm_pkg::ccdm_kind_t reqKind,
	input  wire logic [ADDR_W-1:0]    reqAddr,
	input  wire logic                 reqWdata,
	output logic                      rspValid,
	output logic                      rspData,
	output logic [7:0]                bitPos,
	output logic                      windowOpen,
	output logic                      phi1,
	output logic                      phi2,
	output logic                      phi3,
	output logic                      phi4,
	output logic                      ceOut,
	output logic                      weOut,
	output logic                      csOut,
	output logic [ADDR_W-1:0]         addrOut,
	output logic                      dinOut,
	input  wire logic                 doutIn
);
	import ccdm_pkg::*;

	localparam int HALF_MAX_CYC = `CCDM_DN(HALF_MAX_NS);
	localparam int SEG_CYC = `CCDM_PT_CYC + `CCDM_OV_CYC + `CCDM_HD_CYC;
	localparam int WMAX_CYC = HALF_MAX_CYC - SEG_CYC;
	localparam int WMIN_RAW = `CCDM_HALF_MIN_CYC - SEG_CYC;
	localparam int WMIN_CYC = (WMIN_RAW > `CCDM_FC_CYC) ?
	                          WMIN_RAW : `CCDM_FC_CYC;
	localparam int NEED_CYC = `CCDM_RTW_CYC + `CCDM_CP_CYC + 2;
	localparam int WC_W = $clog2(WMAX_CYC + 1) + 1;
	localparam int AC_W = $clog2(MAX_ACC + 1);

	localparam logic [WC_W-1:0] WIN_MAX = WC_W'(WMAX_CYC);
	localparam logic [WC_W-1:0] WIN_MIN = WC_W'(WMIN_CYC);
	localparam logic [WC_W-1:0] FC_LIM  = WC_W'(`CCDM_FC_CYC);
	localparam logic [WC_W-1:0] NEED    = WC_W'(NEED_CYC);
	localparam logic [WC_W-1:0] WC_ONE  = WC_W'(1);
	localparam logic [AC_W-1:0] ACC_LIM = AC_W'(MAX_ACC);
	localparam logic [AC_W-1:0] AC_ONE  = AC_W'(1);
	localparam logic [4:0]      SEG_ONE = 5'h01;

	if (ADDR_W != `CCDM_ADDR_W) begin : g_bad_addr
		$error("address width must match the loop count");
	end
	if (MAX_ACC < 1 || MAX_ACC > `CCDM_MAX_ACC) begin : g_bad_acc
		$error("MAX_ACC out of range");
	end
	if (HALF_MAX_NS > `CCDM_T_HALF_MAX_NS ||
	    WMAX_CYC < NEED_CYC + `CCDM_FC_CYC) begin : g_bad_half
		$error("HALF_MAX_NS cannot hold one access");
	end

	ccdm_acc_if acc ();

	ccdm_state_t         state_q;
	ccdm_state_t         state_d;
	logic [4:0]          segCnt_q;
	logic [WC_W-1:0]     winCnt_q;
	logic [AC_W-1:0]     accCnt_q;
	logic [3:0]          phase_q;
	logic                reqReady_q;
	logic                rspValid_q;
	logic                rspData_q;
	logic [7:0]          bitPos_q;
	logic                winOpen_q;
	logic                cs_q;
	logic [ADDR_W-1:0]   addr_q;
	logic                din_q;

	// phase order: two, two+one, one, window, four, four+three, three
	function automatic logic [3:0] phaseOf(input ccdm_state_t s);
		case (s)
			ST_SHIFT_B: phaseOf = 4'h2;
			ST_OVL_BA:  phaseOf = 4'h3;
			ST_HOLD_A:  phaseOf = 4'h1;
			ST_SHIFT_D: phaseOf = 4'h8;
			ST_OVL_DC:  phaseOf = 4'hC;
			ST_HOLD_C:  phaseOf = 4'h4;
			default:    phaseOf = 4'h0;
		endcase
	endfunction

	function automatic logic [4:0] segLen(input ccdm_state_t s);
		case (s)
			ST_SHIFT_B, ST_SHIFT_D: segLen = 5'(`CCDM_PT_CYC);
			ST_OVL_BA, ST_OVL_DC:   segLen = 5'(`CCDM_OV_CYC);
			default:                segLen = 5'(`CCDM_HD_CYC);
		endcase
	endfunction

	function automatic logic isWin(input ccdm_state_t s);
		isWin = (s == ST_WIN_A) || (s == ST_WIN_C);
	endfunction

	wire             inWin   = isWin(state_q);
	wire             segDone = (segCnt_q == segLen(state_q) - SEG_ONE);
	wire [WC_W-1:0]  winNeed = winCnt_q + NEED;
	// a started cycle plus the off gap must end inside the half period
	wire             fits    = (winNeed <= WIN_MAX);
	wire             countOk = (accCnt_q < ACC_LIM);
	wire             fcDone  = (winCnt_q >= FC_LIM);
	wire             accept  = reqValid && reqReady_q;
	wire             minDone = (winCnt_q >= WIN_MIN);
	// leave only when no cycle runs, so the strobe is long low
	wire             winExit = inWin && minDone && !acc.busy &&
	                           !accept &&
	                           (!reqValid || !fits || !countOk);
	wire             stayWin = isWin(state_d) && (state_d == state_q);
	wire             ready_d = stayWin && fcDone && fits && countOk &&
	                           !acc.busy && !accept;
	wire             shiftEv = inWin && !isWin(state_d);

	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_SHIFT_B: if (segDone) state_d = ST_OVL_BA;
			ST_OVL_BA:  if (segDone) state_d = ST_HOLD_A;
			ST_HOLD_A:  if (segDone) state_d = ST_WIN_A;
			ST_WIN_A:   if (winExit) state_d = ST_SHIFT_D;
			ST_SHIFT_D: if (segDone) state_d = ST_OVL_DC;
			ST_OVL_DC:  if (segDone) state_d = ST_HOLD_C;
			ST_HOLD_C:  if (segDone) state_d = ST_WIN_C;
			ST_WIN_C:   if (winExit) state_d = ST_SHIFT_B;
			default:    state_d = ST_SHIFT_B;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q  <= ST_WIN_C;
			segCnt_q <= 5'h00;
			phase_q  <= 4'h0;
		end else begin
			state_q  <= state_d;
			segCnt_q <= (state_d != state_q) ? 5'h00 : segCnt_q + SEG_ONE;
			phase_q  <= phaseOf(state_d);
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			winCnt_q <= '0;
			accCnt_q <= '0;
		end else if (!inWin) begin
			winCnt_q <= '0;
			accCnt_q <= '0;
		end else begin
			winCnt_q <= winCnt_q + WC_ONE;
			accCnt_q <= accept ? accCnt_q + AC_ONE : accCnt_q;
		end
	end

	// loop position mirrors the device shift, modulo the loop length
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			bitPos_q  <= 8'h00;
			winOpen_q <= 1'b0;
		end else begin
			bitPos_q  <= shiftEv ? bitPos_q + 8'h01 : bitPos_q;
			winOpen_q <= isWin(state_d);
		end
	end

	// pins only change at accept, while no strobe is high
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			addr_q <= '0;
			din_q  <= 1'b0;
		end else if (accept) begin
			addr_q <= reqAddr;
			din_q  <= reqWdata;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cs_q <= 1'b0;
		end else if (accept) begin
			cs_q <= 1'b1;
		end else if (acc.done) begin
			cs_q <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			reqReady_q <= 1'b0;
			rspValid_q <= 1'b0;
			rspData_q  <= 1'b0;
		end else begin
			reqReady_q <= ready_d;
			rspValid_q <= acc.done;
			// device output is inverted; undo it here
			rspData_q  <= acc.done ? ~acc.rdBit : rspData_q;
		end
	end

	assign acc.start = accept;
	assign acc.kind  = reqKind;

	ccdm_strobe_seq u_seq (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.doutIn  (doutIn),
		.acc     (acc)
	);

	assign reqReady   = reqReady_q;
	assign rspValid   = rspValid_q;
	assign rspData    = rspData_q;
	assign bitPos     = bitPos_q;
	assign windowOpen = winOpen_q;
	assign phi1       = phase_q[0];
	assign phi2       = phase_q[1];
	assign phi3       = phase_q[2];
	assign phi4       = phase_q[3];
	assign ceOut      = acc.ce;
	assign weOut      = acc.we;
	assign csOut      = cs_q;
	assign addrOut    = addr_q;
	assign dinOut     = din_q;
endmodule

// *** logic/ccdm_pkg.sv ***
package ccdm_pkg;

	typedef enum logic [1:0] {
		KIND_READ            = 2'h0,
		KIND_WRITE           = 2'h1,
		KIND_READ_THEN_WRITE = 2'h2
	} ccdm_kind_t;

	typedef enum logic [7:0] {
		ST_SHIFT_B  = 8'h01,
		ST_OVL_BA   = 8'h02,
		ST_HOLD_A   = 8'h04,
		ST_WIN_A    = 8'h08,
		ST_SHIFT_D  = 8'h10,
		ST_OVL_DC   = 8'h20,
		ST_HOLD_C   = 8'h40,
		ST_WIN_C    = 8'h80
	} ccdm_state_t;

endpackage

// *** logic/ccdm_strobe_seq.sv ***
`timescale 1ns/1ps
`include "ccdm_cfg.svh"

module ccdm_strobe_seq (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic doutIn,
	ccdm_acc_if.seq  acc
);
	import ccdm_pkg::*;

	localparam logic [6:0] ONE = 7'h01;

	logic [6:0] cnt_q;
	ccdm_kind_t kind_q;
	logic       busy_q;
	logic       done_q;
	logic       ce_q;
	logic       we_q;
	logic       bit_q;

	function automatic logic [6:0] ceEnd(input ccdm_kind_t k);
		case (k)
			KIND_WRITE:           ceEnd = 7'(`CCDM_CEW_CYC);
			KIND_READ_THEN_WRITE: ceEnd = 7'(`CCDM_CRW_CYC);
			default:              ceEnd = 7'(`CCDM_CER_CYC);
		endcase
	endfunction

	function automatic logic [6:0] cycEnd(input ccdm_kind_t k);
		case (k)
			KIND_WRITE:           cycEnd = 7'(`CCDM_WR_CYC);
			KIND_READ_THEN_WRITE: cycEnd = 7'(`CCDM_RTW_CYC);
			default:              cycEnd = 7'(`CCDM_RD_CYC);
		endcase
	endfunction

	if (`CCDM_RD_CYC < `CCDM_CER_CYC + `CCDM_OFF_CYC ||
	    `CCDM_RTW_CYC < `CCDM_CRW_CYC + `CCDM_OFF_CYC) begin : g_bad_off
		$error("strobe off time too short");
	end

	// the spare kind code behaves as a pure read: no write pulse at all
	wire       isRead  = (kind_q != KIND_WRITE) &&
	                     (kind_q != KIND_READ_THEN_WRITE);
	wire       isWrite = (kind_q == KIND_WRITE);
	wire [6:0] weOn    = isWrite ? 7'(`CCDM_CW_CYC) : 7'(`CCDM_WD_CYC);
	wire [6:0] weOff   = weOn + 7'(`CCDM_WP_CYC);
	wire       ceFall  = busy_q && (cnt_q == ceEnd(kind_q));
	wire       weRise  = busy_q && !isRead && (cnt_q == weOn);
	wire       weFall  = busy_q && !isRead && (cnt_q == weOff);
	// sample lands before the write pulse of a read_then_write_cycle
	wire       sampleHit = busy_q && !isWrite &&
	                       (cnt_q == 7'(`CCDM_CO_CYC));
	wire       endHit  = busy_q && (cnt_q == cycEnd(kind_q));
	wire       begin_w = acc.start && !busy_q;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q  <= 7'h00;
			kind_q <= KIND_READ;
			busy_q <= 1'b0;
		end else if (begin_w) begin
			cnt_q  <= ONE;
			kind_q <= acc.kind;
			busy_q <= 1'b1;
		end else if (busy_q) begin
			cnt_q  <= cnt_q + ONE;
			busy_q <= !endHit;
		end
	end

	// strobe rises with the start; write pulse sits inside it
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ce_q <= 1'b0;
			we_q <= 1'b0;
		end else begin
			ce_q <= begin_w | (ce_q & ~ceFall);
			we_q <= weRise | (we_q & ~weFall);
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			bit_q  <= 1'b0;
			done_q <= 1'b0;
		end else begin
			done_q <= endHit;
			if (sampleHit) begin
				bit_q <= doutIn;
			end
		end
	end

	assign acc.busy  = busy_q;
	assign acc.done  = done_q;
	assign acc.ce    = ce_q;
	assign acc.we    = we_q;
	assign acc.rdBit = bit_q;
endmodule

// *** tb/ccdm_chk.sv ***
`timescale 1ns/1ps
module ccdm_chk
	import ccdm_pkg::*;
#(
	parameter int MAX_ACC     = 16,
	parameter int HALF_MAX_NS = 10000
) (
	input wire logic       sys_clk,
	input wire logic       rst_n,
	input wire logic       reqValid,
	input wire logic       reqReady,
	input wire ccdm_kind_t reqKind,
	input wire logic       rspValid,
	input wire logic       windowOpen,
	input wire logic       phi1,
	input wire logic       phi2,
	input wire logic       phi3,
	input wire logic       phi4,
	input wire logic       ceOut,
	input wire logic       weOut,
	input wire logic       csOut,
	input wire logic [5:0] addrOut,
	input wire logic       dinOut
);
	localparam int HALF_CYC = HALF_MAX_NS / 10;
	ccdm_kind_t kindQ;
	logic       p2q, p4q, anyPhi, shiftEdge, acc;
	int         ceHiQ, ceOffQ, weHiQ, quietQ, gapQ, accQ;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	assign anyPhi    = phi1 | phi2 | phi3 | phi4;
	assign shiftEdge = (phi2 && !p2q) || (phi4 && !p4q);
	assign acc       = reqValid && reqReady;
	always_ff @(posedge sys_clk) begin
		p2q    <= phi2;
		p4q    <= phi4;
		ceHiQ  <= ceOut ? ceHiQ + 1 : 0;
		ceOffQ <= ceOut ? 0 : ceOffQ + 1;
		weHiQ  <= weOut ? weHiQ + 1 : 0;
		quietQ <= anyPhi ? 0 : quietQ + 1;
		gapQ   <= (!rst_n || shiftEdge) ? 0 : gapQ + 1;
		accQ   <= (!rst_n || shiftEdge) ? 0 : accQ + 32'($rose(ceOut));
		if (acc)
			kindQ <= reqKind;
	end
	a_in_window: assert property (ceOut |-> !anyPhi)
		else $error("strobe high outside access window");
	a_win_flag: assert property ((anyPhi |-> !windowOpen) and
		(ceOut |-> windowOpen))
		else $error("window flag disagrees with phases");
	a_acc_limit: assert property (accQ <= MAX_ACC)
		else $error("too many accesses between shifts");
	a_read_quiet: assert property (ceOut && kindQ != KIND_WRITE &&
		kindQ != KIND_READ_THEN_WRITE |-> !weOut)
		else $error("write strobe during read");
	a_ce_late: assert property ($rose(ceOut) |-> quietQ >= 28)
		else $error("strobe too soon after phase fall");
	a_shift_gap: assert property (shiftEdge |-> !ceOut && ceOffQ >= 4)
		else $error("strobe too close to shift");
	a_ce_rest: assert property ($rose(ceOut) |-> ceOffQ >= 14)
		else $error("strobe off time short");
	a_half_max: assert property (gapQ < HALF_CYC)
		else $error("half period too long");
	a_phase_lead: assert property (($rose(phi1) |-> $past(phi2, 20))
		and ($rose(phi3) |-> $past(phi4, 20)))
		else $error("phase lead too short");
	a_phase_ovl: assert property (($fell(phi2) |-> phi1 && $past(phi1, 3))
		and ($fell(phi4) |-> phi3 && $past(phi3, 3)))
		else $error("phase overlap too short");
	a_sel_hold: assert property ((ceOut || $fell(ceOut)) |-> csOut &&
		(!$past(ceOut) || ($stable(addrOut) && $stable(dinOut))))
		else $error("select or address moved in cycle");
	a_we_late: assert property (($rose(weOut) |-> $past(ceOut, 10))
		and ($rose(weOut) && kindQ == KIND_READ_THEN_WRITE |-> $past(ceOut, 30)))
		else $error("write strobe too early");
	a_we_width: assert property ($fell(weOut) |-> weHiQ >= 10 && ceOut)
		else $error("write pulse short or late");
	a_ce_width: assert property ($fell(ceOut) |-> ceHiQ >=
		(kindQ == KIND_READ_THEN_WRITE ? 44 : 28))
		else $error("strobe on time short");
	a_cycle_len: assert property ((acc && reqKind != KIND_READ_THEN_WRITE
		|-> ##48 rspValid) and (acc && reqKind == KIND_READ_THEN_WRITE
		|-> ##64 rspValid))
		else $error("cycle length wrong");
endmodule

bind ccdm_ctrl ccdm_chk #(
	.MAX_ACC     (MAX_ACC),
	.HALF_MAX_NS (HALF_MAX_NS)
) chk_u (
	.sys_clk    (sys_clk),
	.rst_n      (rst_n),
	.reqValid   (reqValid),
	.reqReady   (reqReady),
	.reqKind    (reqKind),
	.rspValid   (rspValid),
	.windowOpen (windowOpen),
	.phi1       (phi1),
	.phi2       (phi2),
	.phi3       (phi3),
	.phi4       (phi4),
	.ceOut      (ceOut),
	.weOut      (weOut),
	.csOut      (csOut),
	.addrOut    (addrOut),
	.dinOut     (dinOut)
);

// *** tb/ccdm_dev_model.sv ***
`timescale 1ns/1ps
module ccdm_dev_model (
	input wire logic       sys_clk,
	input wire logic       phi2,
	input wire logic       phi4,
	input wire logic       ce,
	input wire logic       we,
	input wire logic       cs,
	input wire logic [5:0] addr,
	input wire logic       din,
	output logic           dout
);
	bit         loops [64][256];
	int         pos;
	logic [5:0] selQ;
	logic       validQ;
	logic       wrQ;
	logic       junkQ;
	initial begin
		pos = 0;
		validQ = 0;
		wrQ = 0;
		junkQ = 0;
		foreach (loops[a, p])
			loops[a][p] = ^(a * 3 + p);
	end
	// junk toggles so an early sample cannot match by luck
	always @(posedge sys_clk) junkQ <= ~junkQ;
	always @(posedge phi2 or posedge phi4) pos = (pos + 1) % 256;
	always @(posedge ce) begin
		selQ = addr;
		wrQ = 0;
		validQ = 0;
		#249 validQ = ce;
	end
	always @(negedge ce) validQ = 0;
	always @(posedge we) if (ce) begin
		loops[selQ][pos] = din;
		wrQ = 1;
	end
	// pull-up termination sets the released level
	assign dout = !(ce && cs) ? 1'b1 :
		(wrQ || !validQ) ? junkQ : !loops[selQ][pos];
endmodule

// *** tb/tb.sv ***
`timescale 1ns/1ps
`define CMP(nm, ex, got) begin \
	checks_done++; \
	if ((got) !== (ex)) begin \
		err_total++; \
		$display("wrong value %s expected %0h seen %0h", nm, ex, got); \
	end \
end
module tb;
	import ccdm_pkg::*;
	logic       sys_clk = 1'b0;
	logic       rst_n = 1'b0;
	logic       reqValid = 1'b0;
	logic       reqWdata = 1'b0;
	ccdm_kind_t reqKind = KIND_READ;
	logic [5:0] reqAddr = 6'h00;
	logic       reqReady, rspValid, rspData, windowOpen, doutIn;
	logic       phi1, phi2, phi3, phi4, ceOut, weOut, csOut, dinOut;
	logic [7:0] bitPos;
	logic [5:0] addrOut;
	logic       p2q = 1'b0;
	logic       p4q = 1'b0;
	bit         refBits [64][256];
	int         expQ [$];
	int         shifts, e, err_total, checks_done;

	always #5 sys_clk = ~sys_clk;

	ccdm_ctrl dut_u (
		.sys_clk(sys_clk), .rst_n(rst_n), .reqValid(reqValid),
		.reqReady(reqReady), .reqKind(reqKind), .reqAddr(reqAddr),
		.reqWdata(reqWdata), .rspValid(rspValid), .rspData(rspData),
		.bitPos(bitPos), .windowOpen(windowOpen), .phi1(phi1),
		.phi2(phi2), .phi3(phi3), .phi4(phi4), .ceOut(ceOut),
		.weOut(weOut), .csOut(csOut), .addrOut(addrOut),
		.dinOut(dinOut), .doutIn(doutIn)
	);
	ccdm_dev_model model_u (
		.sys_clk(sys_clk), .phi2(phi2), .phi4(phi4), .ce(ceOut),
		.we(weOut), .cs(csOut), .addr(addrOut), .din(dinOut),
		.dout(doutIn)
	);

	task automatic complete_run();
		$display("checks %0d errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	always @(posedge sys_clk) begin
		p2q <= phi2;
		p4q <= phi4;
		if ((phi2 && !p2q) || (phi4 && !p4q))
			shifts <= shifts + 1;
		if (rspValid) begin
			e = expQ.size() > 0 ? expQ.pop_front() : 3;
			if (e != 2)
				`CMP("rspData", 2'(e), {1'b0, rspData})
		end
	end

	task automatic req(input ccdm_kind_t k, input logic [5:0] a,
			input logic d);
		int n;
		int p;
		@(posedge sys_clk);
		reqValid <= 1'b1;
		reqKind  <= k;
		reqAddr  <= a;
		reqWdata <= d;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (!(reqValid && reqReady) && n < 2000);
		if (n >= 2000) begin
			err_total++;
			complete_run();
		end
		p = shifts % 256;
		`CMP("bitPos", 8'(p), bitPos)
		`CMP("windowOpen", 1'b1, windowOpen)
		// rtw returns the bit as it stood before the store
		expQ.push_back(k == KIND_WRITE ? 2 : int'(refBits[a][p]));
		if (k == KIND_WRITE || k == KIND_READ_THEN_WRITE)
			refBits[a][p] = d;
		reqValid <= 1'b0;
	endtask

	initial begin
		#(10 * 60000);
		err_total++;
		complete_run();
	end

	initial begin
		logic [5:0] a;
		foreach (refBits[i, j])
			refBits[i][j] = ^(i * 3 + j);
		void'($urandom(32'h1001));
		repeat (12) @(posedge sys_clk);
		rst_n <= 1'b1;
		// every loop once, back to back, fills windows to the limit
		for (int i = 0; i < 64; i++)
			req(KIND_READ, 6'(i), 1'b0);
		// few loops so stores are read back, kind 3 acts as read
		for (int i = 0; i < 48; i++) begin
			a = 6'($urandom_range(3));
			req(ccdm_kind_t'($urandom_range(3)), a, 1'($urandom));
		end
		repeat (3000) @(posedge sys_clk);
		for (int i = 0; i < 8; i++)
			req(KIND_READ, 6'(i), 1'b0);
		repeat (100) @(posedge sys_clk);
		`CMP("pending", 0, expQ.size())
		complete_run();
	end
endmodule
